// [ctb_pkg.sv]
/*
 * ctb_pkg: shared constants and types of the control timer register bank.
 * assumes an apb slave, register index = printed offset, byte address = index * 4.
 */
package ctb_pkg;

    // ==========================================
    // register indices
    localparam logic [5:0] IDX_PRIMARY_CONTROL   = 6'h00;
    localparam logic [5:0] IDX_WAVEFORM_MODE     = 6'h01;
    localparam logic [5:0] IDX_OUTPUT_ROUTING    = 6'h02;
    localparam logic [5:0] IDX_OVERRIDE_VALUE    = 6'h03;
    localparam logic [5:0] IDX_COMMAND_STROBES   = 6'h04;
    localparam logic [5:0] IDX_EVENT_INPUT_A     = 6'h08;
    localparam logic [5:0] IDX_EVENT_INPUT_B     = 6'h09;
    localparam logic [5:0] IDX_IRQ_ENABLE        = 6'h0C;
    localparam logic [5:0] IDX_IRQ_FLAGS         = 6'h0D;
    localparam logic [5:0] IDX_TIMER_STATUS      = 6'h0E;
    localparam logic [5:0] IDX_INPUT_A_MODE      = 6'h10;
    localparam logic [5:0] IDX_INPUT_B_MODE      = 6'h11;
    localparam logic [5:0] IDX_FAULT_OUTPUT      = 6'h12;
    localparam logic [5:0] IDX_DELAY_CONTROL     = 6'h14;
    localparam logic [5:0] IDX_DELAY_VALUE       = 6'h15;
    localparam logic [5:0] IDX_DITHER_CONTROL    = 6'h18;
    localparam logic [5:0] IDX_DITHER_VALUE      = 6'h19;
    localparam logic [5:0] IDX_DEBUG_CONTROL     = 6'h1E;
    localparam logic [5:0] IDX_CAPTURE_A         = 6'h22;
    localparam logic [5:0] IDX_CAPTURE_B         = 6'h24;
    localparam logic [5:0] IDX_COMPARE_A_SET     = 6'h28;
    localparam logic [5:0] IDX_COMPARE_A_CLEAR   = 6'h2A;
    localparam logic [5:0] IDX_COMPARE_B_SET     = 6'h2C;
    localparam logic [5:0] IDX_COMPARE_B_CLEAR   = 6'h2E;

    // ==========================================
    // reset values and field positions
    localparam logic [7:0]  RST_BYTE             = 8'h00;
    localparam logic [15:0] RST_COMPARE          = 16'h0000;
    localparam logic [15:0] RST_COMPARE_B_CLEAR  = 16'h0FFF;
    localparam int          POS_SCAPTURE_A       = 3;
    localparam int          POS_SCAPTURE_B       = 4;
    localparam int          POS_FLAG_OVF         = 0;

    // ==========================================
    // field encodings
    localparam logic [1:0] SRC_INTERNAL_20MHZ_OSCILLATOR   = 2'h0;
    localparam logic [1:0] SRC_EXTERNAL = 2'h2;
    localparam logic [1:0] SRC_SYSTEM   = 2'h3;
    localparam logic [1:0] CPRES_DIV1   = 2'h0;
    localparam logic [1:0] CPRES_DIV4   = 2'h1;
    localparam logic [1:0] CPRES_DIV32  = 2'h2;
    localparam logic [4:0] MASK_DIV1    = 5'h00;
    localparam logic [4:0] MASK_DIV4    = 5'h03;
    localparam logic [4:0] MASK_DIV32   = 5'h1F;

    localparam logic [1:0] SLEEP_ACTIVE    = 2'h0;
    localparam logic [1:0] SLEEP_IDLE      = 2'h1;
    localparam logic [1:0] SLEEP_STANDBY   = 2'h2;
    localparam logic [1:0] SLEEP_POWERDOWN = 2'h3;

    typedef struct packed {
        logic       unused7;
        logic [1:0] timer_clock_source;
        logic [1:0] counter_prescaler;
        logic [1:0] sync_prescaler;
        logic       enable;
    } ctb_primary_t;

    typedef struct packed {
        logic [11:0] a_set;
        logic [11:0] a_clear;
        logic [11:0] b_set;
        logic [11:0] b_clear;
    } ctb_compare_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_RESP = 2'b10
    } ctb_bus_state_t;

endpackage

// [ctb_timer_regs.sv]
/*
 * ctb_timer_regs: apb register bank, protection, sleep gating and domain
 * staging of a 12-bit control timer with a simple set/clear waveform pair.
 * assumes osc_tick and ext_tick are one-cycle pulses synchronous to pclk and
 * that protect_unlock is the cpu's io key window, already timed by the cpu.
 */
// Implementation choice: register access over APB.
`timescale 1ns/100ps
module ctb_timer_regs #(
    parameter int CW = 12
) (
    // apb
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // system
    input  wire logic [1:0]  sleep_state,
    input  wire logic        protect_unlock,
    input  wire logic        osc_tick,
    input  wire logic        ext_tick,
    // timer outputs
    output logic             wave_a,
    output logic             wave_b,
    output logic             timer_running
);

    // ==========================================
    // bus side state
    ctb_pkg::ctb_bus_state_t state_reg, state_next;
    logic [31:0]             prdata_reg, prdata_next;
    logic                    pready_reg, pready_next;
    logic                    pslverr_reg, pslverr_next;
    ctb_pkg::ctb_primary_t   primary_reg, primary_next;
    logic [7:0]              misc_reg [0:31];
    logic [7:0]              misc_next [0:31];
    logic [7:0]              fault_reg, fault_next;
    logic [7:0]              flags_reg, flags_next;
    ctb_pkg::ctb_compare_t   cmp_reg, cmp_next;
    logic [CW-1:0]           cap_a_reg, cap_a_next;
    logic [CW-1:0]           cap_b_reg, cap_b_next;
    logic                    cap_req_reg, cap_req_next;
    logic                    cap_sel_reg, cap_sel_next;
    logic                    ack_s1_reg, ack_s2_reg, ack_d_reg;
    logic                    wrap_s1_reg, wrap_s2_reg, wrap_d_reg;

    // ==========================================
    // timer side state
    ctb_pkg::ctb_primary_t   cfg_s1_reg, cfg_s2_reg;
    ctb_pkg::ctb_compare_t   cmps_s1_reg, cmps_s2_reg;
    logic                    req_s1_reg, req_s2_reg;
    logic                    ack_reg, ack_next;
    logic [CW-1:0]           cap_val_reg, cap_val_next;
    logic [2:0]              sdiv_reg, sdiv_next;
    logic [4:0]              cdiv_reg, cdiv_next;
    logic [CW-1:0]           cnt_reg, cnt_next;
    logic                    wrap_tgl_reg, wrap_tgl_next;
    logic                    wa_reg, wa_next, wb_reg, wb_next;
    logic                    run_reg, run_next;

    logic [5:0]              idx;
    logic                    wr_go, enable_ready, cmd_ready, halted;
    logic                    src_tick, sync_tick, cnt_tick;
    logic [2:0]              smask;
    logic [4:0]              cmask;

    assign idx          = paddr[7:2];
    assign wr_go        = psel && penable && pwrite && pready_reg;
    assign enable_ready = (primary_reg.enable == cfg_s2_reg.enable);
    // judged on the delayed ack, so ready never shows before the capture word has landed
    assign cmd_ready    = (cap_req_reg == ack_d_reg);

    // ==========================================
    // bus and register next state
    always_comb begin
        state_next   = state_reg;
        prdata_next  = prdata_reg;
        pready_next  = 1'b0;
        pslverr_next = 1'b0;
        primary_next = primary_reg;
        fault_next   = fault_reg;
        flags_next   = flags_reg;
        cmp_next     = cmp_reg;
        cap_a_next   = cap_a_reg;
        cap_b_next   = cap_b_reg;
        cap_req_next = cap_req_reg;
        cap_sel_next = cap_sel_reg;
        for (int i = 0; i < 32; i++) begin
            misc_next[i] = misc_reg[i];
        end
        // counter wrap seen, set wins over a same-cycle clear
        if (wrap_s2_reg != wrap_d_reg) begin
            flags_next[ctb_pkg::POS_FLAG_OVF] = 1'b1;
        end
        case (state_reg)
            ctb_pkg::ST_IDLE: begin
                if (psel && !penable) begin
                    state_next   = ctb_pkg::ST_RESP;
                    pready_next  = 1'b1;
                    prdata_next  = 32'h0000_0000;
                    case (idx)
                        ctb_pkg::IDX_PRIMARY_CONTROL: prdata_next[7:0] = primary_reg;
                        ctb_pkg::IDX_WAVEFORM_MODE, ctb_pkg::IDX_OUTPUT_ROUTING,
                        ctb_pkg::IDX_OVERRIDE_VALUE, ctb_pkg::IDX_EVENT_INPUT_A,
                        ctb_pkg::IDX_EVENT_INPUT_B, ctb_pkg::IDX_IRQ_ENABLE,
                        ctb_pkg::IDX_INPUT_A_MODE, ctb_pkg::IDX_INPUT_B_MODE,
                        ctb_pkg::IDX_DELAY_CONTROL, ctb_pkg::IDX_DELAY_VALUE,
                        ctb_pkg::IDX_DITHER_CONTROL, ctb_pkg::IDX_DITHER_VALUE,
                        ctb_pkg::IDX_DEBUG_CONTROL: prdata_next[7:0] = misc_reg[idx[4:0]];
                        ctb_pkg::IDX_COMMAND_STROBES: prdata_next[7:0] = 8'h00;
                        ctb_pkg::IDX_IRQ_FLAGS:       prdata_next[7:0] = flags_reg;
                        ctb_pkg::IDX_TIMER_STATUS:    prdata_next[1:0] = {cmd_ready, enable_ready};
                        ctb_pkg::IDX_FAULT_OUTPUT:    prdata_next[7:0] = fault_reg;
                        ctb_pkg::IDX_CAPTURE_A:       prdata_next[CW-1:0] = cap_a_reg;
                        ctb_pkg::IDX_CAPTURE_B:       prdata_next[CW-1:0] = cap_b_reg;
                        ctb_pkg::IDX_COMPARE_A_SET:   prdata_next[11:0] = cmp_reg.a_set;
                        ctb_pkg::IDX_COMPARE_A_CLEAR: prdata_next[11:0] = cmp_reg.a_clear;
                        ctb_pkg::IDX_COMPARE_B_SET:   prdata_next[11:0] = cmp_reg.b_set;
                        ctb_pkg::IDX_COMPARE_B_CLEAR: prdata_next[11:0] = cmp_reg.b_clear;
                        default: pslverr_next = 1'b1;
                    endcase
                end
            end
            ctb_pkg::ST_RESP: begin
                state_next = ctb_pkg::ST_IDLE;
                if (wr_go && !pslverr_reg) begin
                    case (idx)
                        ctb_pkg::IDX_PRIMARY_CONTROL: begin
                            if (enable_ready) begin
                                primary_next.enable = pwdata[0];
                            end
                            if (!primary_reg.enable) begin
                                primary_next.timer_clock_source = pwdata[6:5];
                                primary_next.counter_prescaler  = pwdata[4:3];
                                primary_next.sync_prescaler     = pwdata[2:1];
                            end
                        end
                        ctb_pkg::IDX_COMMAND_STROBES: begin
                            if (cmd_ready && (pwdata[ctb_pkg::POS_SCAPTURE_A] || pwdata[ctb_pkg::POS_SCAPTURE_B])) begin
                                cap_req_next = ~cap_req_reg;
                                cap_sel_next = pwdata[ctb_pkg::POS_SCAPTURE_B];
                            end
                        end
                        ctb_pkg::IDX_IRQ_FLAGS: begin
                            flags_next = flags_reg & ~pwdata[7:0];
                            if (wrap_s2_reg != wrap_d_reg) begin
                                flags_next[ctb_pkg::POS_FLAG_OVF] = 1'b1;
                            end
                        end
                        ctb_pkg::IDX_FAULT_OUTPUT: begin
                            // only the io key opens this; a locked write still completes
                            if (protect_unlock) begin
                                fault_next = pwdata[7:0];
                            end
                        end
                        ctb_pkg::IDX_COMPARE_A_SET:   cmp_next.a_set   = pwdata[11:0];
                        ctb_pkg::IDX_COMPARE_A_CLEAR: cmp_next.a_clear = pwdata[11:0];
                        ctb_pkg::IDX_COMPARE_B_SET:   cmp_next.b_set   = pwdata[11:0];
                        ctb_pkg::IDX_COMPARE_B_CLEAR: cmp_next.b_clear = pwdata[11:0];
                        ctb_pkg::IDX_TIMER_STATUS, ctb_pkg::IDX_CAPTURE_A,
                        ctb_pkg::IDX_CAPTURE_B: ;
                        default: misc_next[idx[4:0]] = pwdata[7:0];
                    endcase
                end
            end
            default: state_next = ctb_pkg::ST_IDLE;
        endcase
        // capture word is stable in the timer stage once its ack toggles
        if (ack_s2_reg != ack_d_reg) begin
            if (cap_sel_reg) begin
                cap_b_next = cap_val_reg;
            end else begin
                cap_a_next = cap_val_reg;
            end
        end
    end

    // ==========================================
    // timer stage next state
    always_comb begin
        halted = (sleep_state == ctb_pkg::SLEEP_STANDBY) || (sleep_state == ctb_pkg::SLEEP_POWERDOWN);
        case (cfg_s2_reg.timer_clock_source)
            ctb_pkg::SRC_INTERNAL_20MHZ_OSCILLATOR:   src_tick = osc_tick;
            ctb_pkg::SRC_EXTERNAL: src_tick = ext_tick;
            ctb_pkg::SRC_SYSTEM:   src_tick = 1'b1;
            default:               src_tick = 1'b0;
        endcase
        smask = (3'h1 << cfg_s2_reg.sync_prescaler) - 3'h1;
        case (cfg_s2_reg.counter_prescaler)
            ctb_pkg::CPRES_DIV1:  cmask = ctb_pkg::MASK_DIV1;
            ctb_pkg::CPRES_DIV4:  cmask = ctb_pkg::MASK_DIV4;
            ctb_pkg::CPRES_DIV32: cmask = ctb_pkg::MASK_DIV32;
            default:              cmask = ctb_pkg::MASK_DIV1;
        endcase
        run_next      = cfg_s2_reg.enable && !halted;
        sync_tick     = run_reg && src_tick && ((sdiv_reg & smask) == smask);
        cnt_tick      = sync_tick && ((cdiv_reg & cmask) == cmask);
        sdiv_next     = sdiv_reg;
        cdiv_next     = cdiv_reg;
        cnt_next      = cnt_reg;
        wrap_tgl_next = wrap_tgl_reg;
        wa_next       = wa_reg;
        wb_next       = wb_reg;
        if (!cfg_s2_reg.enable) begin
            sdiv_next = 3'h0;
            cdiv_next = 5'h00;
            cnt_next  = '0;
            wa_next   = fault_reg[0];
            wb_next   = fault_reg[1];
        end else if (run_reg && src_tick) begin
            sdiv_next = (sdiv_reg & smask) == smask ? 3'h0 : sdiv_reg + 3'h1;
            if (sync_tick) begin
                cdiv_next = (cdiv_reg & cmask) == cmask ? 5'h00 : cdiv_reg + 5'h01;
            end
            if (cnt_tick) begin
                if (cnt_reg == cmps_s2_reg.b_clear) begin
                    cnt_next      = '0;
                    wrap_tgl_next = ~wrap_tgl_reg;
                end else begin
                    cnt_next = cnt_reg + 1'b1;
                end
                if (cnt_reg == cmps_s2_reg.a_set) wa_next = 1'b1;
                if (cnt_reg == cmps_s2_reg.a_clear) wa_next = 1'b0;
                if (cnt_reg == cmps_s2_reg.b_set) wb_next = 1'b1;
                if (cnt_reg == cmps_s2_reg.b_clear) wb_next = 1'b0;
            end
        end
        ack_next     = ack_reg;
        cap_val_next = cap_val_reg;
        if (req_s2_reg != ack_reg) begin
            ack_next     = req_s2_reg;
            cap_val_next = cnt_reg;
        end
    end

    // ==========================================
    // registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg    <= ctb_pkg::ST_IDLE;
            prdata_reg   <= 32'h0000_0000;
            pready_reg   <= 1'b0;
            pslverr_reg  <= 1'b0;
            primary_reg  <= ctb_pkg::RST_BYTE;
            fault_reg    <= ctb_pkg::RST_BYTE;
            flags_reg    <= ctb_pkg::RST_BYTE;
            cmp_reg      <= {ctb_pkg::RST_COMPARE[11:0], ctb_pkg::RST_COMPARE[11:0],
                             ctb_pkg::RST_COMPARE[11:0], ctb_pkg::RST_COMPARE_B_CLEAR[11:0]};
            cap_a_reg    <= '0;
            cap_b_reg    <= '0;
            cap_req_reg  <= 1'b0;
            cap_sel_reg  <= 1'b0;
            for (int i = 0; i < 32; i++) begin
                misc_reg[i] <= ctb_pkg::RST_BYTE;
            end
            ack_s1_reg   <= 1'b0;
            ack_s2_reg   <= 1'b0;
            ack_d_reg    <= 1'b0;
            wrap_s1_reg  <= 1'b0;
            wrap_s2_reg  <= 1'b0;
            wrap_d_reg   <= 1'b0;
            cfg_s1_reg   <= ctb_pkg::RST_BYTE;
            cfg_s2_reg   <= ctb_pkg::RST_BYTE;
            cmps_s1_reg  <= '0;
            cmps_s2_reg  <= '0;
            req_s1_reg   <= 1'b0;
            req_s2_reg   <= 1'b0;
            ack_reg      <= 1'b0;
            cap_val_reg  <= '0;
            sdiv_reg     <= 3'h0;
            cdiv_reg     <= 5'h00;
            cnt_reg      <= '0;
            wrap_tgl_reg <= 1'b0;
            wa_reg       <= 1'b0;
            wb_reg       <= 1'b0;
            run_reg      <= 1'b0;
        end else begin
            state_reg    <= state_next;
            prdata_reg   <= prdata_next;
            pready_reg   <= pready_next;
            pslverr_reg  <= pslverr_next;
            primary_reg  <= primary_next;
            fault_reg    <= fault_next;
            flags_reg    <= flags_next;
            cmp_reg      <= cmp_next;
            cap_a_reg    <= cap_a_next;
            cap_b_reg    <= cap_b_next;
            cap_req_reg  <= cap_req_next;
            cap_sel_reg  <= cap_sel_next;
            for (int i = 0; i < 32; i++) begin
                misc_reg[i] <= misc_next[i];
            end
            ack_s1_reg   <= ack_reg;
            ack_s2_reg   <= ack_s1_reg;
            ack_d_reg    <= ack_s2_reg;
            wrap_s1_reg  <= wrap_tgl_reg;
            wrap_s2_reg  <= wrap_s1_reg;
            wrap_d_reg   <= wrap_s2_reg;
            cfg_s1_reg   <= primary_reg;
            cfg_s2_reg   <= cfg_s1_reg;
            cmps_s1_reg  <= cmp_reg;
            cmps_s2_reg  <= cmps_s1_reg;
            req_s1_reg   <= cap_req_reg;
            req_s2_reg   <= req_s1_reg;
            ack_reg      <= ack_next;
            cap_val_reg  <= cap_val_next;
            sdiv_reg     <= sdiv_next;
            cdiv_reg     <= cdiv_next;
            cnt_reg      <= cnt_next;
            wrap_tgl_reg <= wrap_tgl_next;
            wa_reg       <= wa_next;
            wb_reg       <= wb_next;
            run_reg      <= run_next;
        end
    end

    assign prdata        = prdata_reg;
    assign pready        = pready_reg;
    assign pslverr       = pslverr_reg;
    assign wave_a        = wa_reg;
    assign wave_b        = wb_reg;
    assign timer_running = run_reg;

endmodule // ctb_timer_regs

// [ctb_timer_regs_assertions.sv]
/*
 * ctb_timer_regs_assertions: port-level checks of the control timer register bank.
 * assumes it is bound to ctb_timer_regs and sees only that module's ports.
 */
`timescale 1ns/100ps
module ctb_timer_regs_assertions (
    // apb
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // system and timer
    input wire logic [1:0]  sleep_state,
    input wire logic        protect_unlock,
    input wire logic        osc_tick,
    input wire logic        ext_tick,
    input wire logic        wave_a,
    input wire logic        wave_b,
    input wire logic        timer_running
);
    // ==========================================
    // helpers
    wire logic [5:0] idx   = paddr[7:2];
    wire logic       en_wr = psel && penable && pready && pwrite && (idx == 6'h00) && pwdata[0];

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // ==========================================
    // bus answer
    chk_ready_one_pulse: assert property (pready |=> !pready) else $error("pready longer than one cycle");
    chk_ready_after_setup: assert property (psel && !penable |=> pready) else $error("no answer after setup");
    chk_ready_needs_sel: assert property (!psel |=> !pready) else $error("pready without a request");
    chk_err_with_ready: assert property (pslverr |-> pready) else $error("pslverr without pready");
    chk_unmapped_err: assert property (psel && !penable && idx == 6'h05 |=> pslverr)
        else $error("reserved index answered without error");
    chk_locked_no_err: assert property (pready && idx == ctb_pkg::IDX_FAULT_OUTPUT |-> !pslverr)
        else $error("protected register answered with error");
    // the enable must cross two stages, so it can never show within two cycles of its write
    chk_enable_synced: assert property ($rose(timer_running) |-> !$past(en_wr) && !$past(en_wr, 2))
        else $error("enable reached the timer without synchronising");
    chk_halt_sleep: assert property ((sleep_state[1])[*4] |-> !timer_running)
        else $error("timer running in standby or power-down");
    chk_capture_width: assert property (pready && !pwrite && idx >= 6'h22 |-> prdata[31:12] == 20'h00000)
        else $error("capture or compare read wider than 12 bits");

    cover property (en_wr);
    cover property (pslverr);
    cover property ($fell(timer_running) && sleep_state[1]);
endmodule // ctb_timer_regs_assertions

bind ctb_timer_regs ctb_timer_regs_assertions u_ctb_timer_regs_assertions (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .sleep_state, .protect_unlock, .osc_tick, .ext_tick, .wave_a, .wave_b, .timer_running
);

// [ctb_timer_regs_bench.sv]
/*
 * ctb_timer_regs_bench: self-checking bench of the control timer register bank.
 * assumes ctb_pkg and the bound checker are compiled first; one 10 MHz clock.
 */
`timescale 1ns/100ps
module ctb_timer_regs_bench;
    // ==========================================
    // stimulus and hookup
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic        protect_unlock = 1'b0, osc_tick = 1'b0, ext_tick = 1'b0, err;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [1:0]  sleep_state = 2'h0;
    logic        pready, pslverr, wave_a, wave_b, timer_running;
    int          mismatches = 0, checked = 0;

    `define CHK(nm, exp, got) begin checked++; if ((got) !== (exp)) begin mismatches++; \
        $display("CHECK FAILED %s expected %h seen %h", nm, exp, got); end end

    ctb_timer_regs #(.CW(12)) u_ctb_timer_regs (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sleep_state(sleep_state), .protect_unlock(protect_unlock), .osc_tick(osc_tick),
        .ext_tick(ext_tick), .wave_a(wave_a), .wave_b(wave_b), .timer_running(timer_running)
    );

    initial begin
        forever #50 pclk = ~pclk;
    end

    // oscillator ticks every other cycle; the external source stays quiet
    always @(posedge pclk) begin
        osc_tick <= ~osc_tick;
    end

    // ==========================================
    // apb master: b2b keeps psel up for a setup that follows at once
    task automatic apb(input logic w, input logic [5:0] idx, input logic [31:0] d, input bit b2b);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 40);
        if (pready !== 1'b1) mismatches++;
        rd = prdata;
        err = pslverr;
        if (!b2b) begin
            psel <= 1'b0;
            penable <= 1'b0;
            @(posedge pclk);
        end
    endtask

    task automatic tally_and_finish();
        if (mismatches == 0 && checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // ==========================================
    // scenarios
    task automatic t_reset_map();
        apb(1'b0, ctb_pkg::IDX_COMPARE_B_CLEAR, 32'h0, 1'b0);
        `CHK("compare_b_clear reset", 32'h00000FFF, rd)
        apb(1'b1, 6'h05, 32'h000000FF, 1'b0);
        `CHK("reserved write error", 1'b1, err)
        apb(1'b0, 6'h05, 32'h0, 1'b0);
        `CHK("reserved read data", 32'h0, rd)
    endtask

    task automatic t_protect();
        apb(1'b1, ctb_pkg::IDX_FAULT_OUTPUT, 32'h03, 1'b0);
        `CHK("locked write error", 1'b0, err)
        apb(1'b0, ctb_pkg::IDX_FAULT_OUTPUT, 32'h0, 1'b0);
        `CHK("locked write kept", 32'h0, rd)
        apb(1'b1, ctb_pkg::IDX_WAVEFORM_MODE, 32'h02, 1'b0);
        apb(1'b0, ctb_pkg::IDX_WAVEFORM_MODE, 32'h0, 1'b0);
        `CHK("unprotected write", 32'h02, rd)
        protect_unlock <= 1'b1;
        apb(1'b1, ctb_pkg::IDX_FAULT_OUTPUT, 32'h03, 1'b0);
        protect_unlock <= 1'b0;
        apb(1'b0, ctb_pkg::IDX_FAULT_OUTPUT, 32'h0, 1'b0);
        `CHK("unlocked write", 32'h03, rd)
        repeat (6) @(posedge pclk);
        `CHK("idle wave levels", 2'b11, {wave_a, wave_b})
    endtask

    task automatic t_fields();
        for (int v = 0; v < 4; v++) begin
            apb(1'b1, ctb_pkg::IDX_PRIMARY_CONTROL, {25'h0, v[1:0], v[1:0], v[1:0], 1'b0}, 1'b0);
            apb(1'b0, ctb_pkg::IDX_PRIMARY_CONTROL, 32'h0, 1'b0);
            `CHK("field codes", {25'h0, v[1:0], v[1:0], v[1:0], 1'b0}, rd)
        end
    endtask

    // system clock, divide by 1; the disable right behind falls inside the enable sync
    task automatic t_enable();
        apb(1'b1, ctb_pkg::IDX_PRIMARY_CONTROL, 32'h61, 1'b1);
        apb(1'b1, ctb_pkg::IDX_PRIMARY_CONTROL, 32'h60, 1'b0);
        repeat (6) @(posedge pclk);
        `CHK("running after enable", 1'b1, timer_running)
        apb(1'b1, ctb_pkg::IDX_PRIMARY_CONTROL, 32'h1F, 1'b0);
        apb(1'b0, ctb_pkg::IDX_PRIMARY_CONTROL, 32'h0, 1'b0);
        `CHK("fields held while enabled", 32'h61, rd)
    endtask

    task automatic cap(output logic [11:0] v);
        int n;
        apb(1'b1, ctb_pkg::IDX_COMMAND_STROBES, 32'h1 << ctb_pkg::POS_SCAPTURE_A, 1'b0);
        repeat (8) @(posedge pclk);
        n = 0;
        rd = 32'h0;
        while (rd[1] !== 1'b1 && n < 20) begin
            apb(1'b0, ctb_pkg::IDX_TIMER_STATUS, 32'h0, 1'b0);
            n++;
        end
        `CHK("command ready", 1'b1, rd[1])
        apb(1'b0, ctb_pkg::IDX_CAPTURE_A, 32'h0, 1'b0);
        `CHK("capture upper bits", 20'h0, rd[31:12])
        v = rd[11:0];
    endtask

    // counter advance across 200 sleeping cycles tells running from halted
    task automatic t_sleep();
        logic [11:0] c0, c1, d;
        for (int s = 1; s < 4; s++) begin
            cap(c0);
            sleep_state <= s[1:0];
            repeat (200) @(posedge pclk);
            `CHK("running in sleep", (s == 1), timer_running)
            sleep_state <= ctb_pkg::SLEEP_ACTIVE;
            cap(c1);
            d = c1 - c0;
            `CHK("advance over sleep", (s == 1), (d > 12'd150))
        end
    endtask

    // osc source, sync div 2, counter div 4: one count per 16 cycles, 417 cycles between captures
    task automatic t_prescale();
        logic [11:0] c0, c1, d;
        apb(1'b1, ctb_pkg::IDX_PRIMARY_CONTROL, 32'h00, 1'b0);
        repeat (4) @(posedge pclk);
        apb(1'b1, ctb_pkg::IDX_PRIMARY_CONTROL, 32'h0B, 1'b0);
        apb(1'b0, ctb_pkg::IDX_PRIMARY_CONTROL, 32'h0, 1'b0);
        `CHK("prescale fields", 32'h0B, rd)
        cap(c0);
        repeat (400) @(posedge pclk);
        cap(c1);
        d = c1 - c0;
        `CHK("prescaled advance", 1'b1, (d >= 12'd25 && d <= 12'd27))
    endtask

    // ==========================================
    // main sequence and watchdog
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset_map();
        t_protect();
        t_fields();
        t_enable();
        t_sleep();
        t_prescale();
        tally_and_finish();
    end

    initial begin
        #(20000 * 100);
        mismatches++;
        tally_and_finish();
    end
endmodule // ctb_timer_regs_bench
